// [rtl/shift4_pkg.sv]
// Purpose: Shared constants and types for the four-stage shift register.
// Assumes: One 125 MHz clock; all inputs come from logic on that clock.
// Notes:   A step word carries mode, first-stage controls and parallel data.
package shift4_pkg;

  localparam int unsigned STAGE_COUNT = 4;
  localparam int unsigned BUF_DEPTH   = 2;
  localparam int unsigned CLK_PERIOD_NS = 8;

  // Step word layout.
  localparam int unsigned STEP_PAR_LSB  = 0;
  localparam int unsigned STEP_HOLD_BIT = 4;
  localparam int unsigned STEP_SET_BIT  = 5;
  localparam int unsigned STEP_MODE_BIT = 6;
  localparam int unsigned STEP_WIDTH    = 7;

  localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 4'h0;
  localparam logic [1:0]             COUNT_FULL  = 2'h2;
  localparam logic [1:0]             COUNT_EMPTY = 2'h0;

  typedef enum logic {
    MODE_SHIFT = 1'b0,
    MODE_LOAD  = 1'b1
  } mode_e;

  typedef logic [STEP_WIDTH-1:0] step_t;

endpackage : shift4_pkg

// [rtl/shift4_reg.sv]
// Purpose: Four-stage shift register with parallel load, first-stage set/hold
//          entry, common reset and a true/complement output control.
// Assumes: Steps arrive as a valid/ready stream; a drain enable can stall it.
// Notes:   Stage outputs pass through the polarity control without a clock.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Behaviour
// R01 - Shift mode moves stage one to two, two to three, three to four.
// R02 - Load mode fills each stage from its own parallel input bit.
// R03 - Stages change only on a rising clock edge, or through reset.
// R04 - Polarity select high shows the stored bits unchanged.
// R05 - Polarity select low shows the inverted stored bits.
// R06 - Polarity acts at once, without a clock, and never alters stored bits.
// R07 - Stage one takes set when holding 0, hold when holding 1.
// R08 - Driving set and hold together makes stage one a plain data capture.
// R09 - Reset high clears all stages at once, independent of the clock.
// R10 - After reset the outputs read zeros in true mode, ones in complement.
module shift4_reg
  import shift4_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   step_valid,
  output logic                        step_ready,
  input  wire logic                   step_mode,
  input  wire logic                   first_set,
  input  wire logic                   first_hold,
  input  wire logic [STAGE_COUNT-1:0] parallel_in_bit,
  input  wire logic                   advance_enable,
  input  wire logic                   polarity_true,
  output logic [STAGE_COUNT-1:0]      stage_output,
  output logic                        stages_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed {
    logic [STAGE_COUNT-1:0] stage;
    step_t [BUF_DEPTH-1:0]  entry;
    logic                   wr_ptr;
    logic                   rd_ptr;
    logic [1:0]             count;
    logic                   ready;
    logic                   busy;
  } state_s;

  localparam state_s STATE_INIT = '{
    stage:  STAGE_RESET,
    entry:  '0,
    wr_ptr: 1'b0,
    rd_ptr: 1'b0,
    count:  COUNT_EMPTY,
    ready:  1'b1,
    busy:   1'b0
  };

  state_s state_reg;
  state_s state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Step word fields.
  function automatic step_t pack_step(
    input logic                   mode_in,
    input logic                   set_in,
    input logic                   hold_in,
    input logic [STAGE_COUNT-1:0] par_in
  );
    step_t w;
    w                              = '0;
    w[STEP_PAR_LSB +: STAGE_COUNT] = par_in;
    w[STEP_HOLD_BIT]               = hold_in;
    w[STEP_SET_BIT]                = set_in;
    w[STEP_MODE_BIT]               = mode_in;
    return w;
  endfunction : pack_step

  function automatic mode_e mode_of(input step_t w);
    return mode_e'(w[STEP_MODE_BIT]);
  endfunction : mode_of

  function automatic logic set_of(input step_t w);
    return w[STEP_SET_BIT];
  endfunction : set_of

  function automatic logic hold_of(input step_t w);
    return w[STEP_HOLD_BIT];
  endfunction : hold_of

  function automatic logic [STAGE_COUNT-1:0] par_of(input step_t w);
    return w[STEP_PAR_LSB +: STAGE_COUNT];
  endfunction : par_of

  ////////////////////////////////////////////////////////////////////////////
  // Next value of the stages.
  function automatic logic first_next(
    input logic cur,
    input logic set_in,
    input logic hold_in
  );
    logic nxt;
    if (cur) begin
      nxt = hold_in; // [R07]
    end else begin
      nxt = set_in; // [R07]
    end
    return nxt;
  endfunction : first_next

  function automatic logic [STAGE_COUNT-1:0] shift_stages(
    input logic [STAGE_COUNT-1:0] cur,
    input logic                   first
  );
    logic [STAGE_COUNT-1:0] nxt;
    nxt[0] = first;
    for (int unsigned k = 1; k < STAGE_COUNT; k++) begin
      nxt[k] = cur[k-1]; // [R01]
    end
    return nxt;
  endfunction : shift_stages

  function automatic logic [STAGE_COUNT-1:0] step_stages(
    input logic [STAGE_COUNT-1:0] cur,
    input step_t                  w
  );
    logic [STAGE_COUNT-1:0] nxt;
    logic                   first;
    nxt   = cur;
    first = first_next(cur[0], set_of(w), hold_of(w));
    unique case (mode_of(w))
      MODE_LOAD: begin
        nxt = par_of(w); // [R02]
      end
      MODE_SHIFT: begin
        nxt = shift_stages(cur, first); // [R01] [R07]
      end
    endcase
    return nxt;
  endfunction : step_stages

  ////////////////////////////////////////////////////////////////////////////
  // Buffer bookkeeping.
  function automatic logic ptr_after(input logic ptr);
    return ~ptr;
  endfunction : ptr_after

  function automatic logic [1:0] count_after(
    input logic [1:0] cur,
    input logic       grow,
    input logic       shrink
  );
    logic [1:0] nxt;
    nxt = cur;
    if (grow && !shrink) begin
      nxt = cur + 2'h1;
    end else if (shrink && !grow) begin
      nxt = cur - 2'h1;
    end
    return nxt;
  endfunction : count_after

  function automatic logic is_full(input logic [1:0] cnt);
    return (cnt == COUNT_FULL);
  endfunction : is_full

  function automatic logic is_empty(input logic [1:0] cnt);
    return (cnt == COUNT_EMPTY);
  endfunction : is_empty

  ////////////////////////////////////////////////////////////////////////////
  // Output polarity.
  function automatic logic show_bit(
    input logic stored,
    input logic true_sel
  );
    logic shown;
    if (true_sel) begin
      shown = stored; // [R04]
    end else begin
      shown = ~stored; // [R05]
    end
    return shown;
  endfunction : show_bit

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry step buffer and the register itself.
  logic  push;
  logic  pop;
  step_t in_word;
  step_t head_word;

  always_comb begin
    state_next = state_reg;
    in_word    = pack_step(step_mode, first_set, first_hold, parallel_in_bit);
    head_word  = state_reg.entry[state_reg.rd_ptr];
    push       = step_valid && state_reg.ready;
    pop        = advance_enable && state_reg.busy;

    if (push) begin
      state_next.entry[state_reg.wr_ptr] = in_word;
      state_next.wr_ptr                  = ptr_after(state_reg.wr_ptr);
    end

    if (pop) begin
      state_next.stage  = step_stages(state_reg.stage, head_word);
      state_next.rd_ptr = ptr_after(state_reg.rd_ptr);
    end

    state_next.count = count_after(state_reg.count, push, pop);
    state_next.ready = !is_full(state_next.count);
    state_next.busy  = !is_empty(state_next.count);
  end

  always_ff @(posedge clk or posedge rst) begin // [R03]
    if (rst) begin
      state_reg <= STATE_INIT; // [R09]
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign step_ready  = state_reg.ready;
  assign stages_busy = state_reg.busy;

  for (genvar i = 0; i < STAGE_COUNT; i++) begin : g_out
    // Pure gating on the stored bit, so polarity never touches the stage.
    assign stage_output[i] = show_bit(state_reg.stage[i], polarity_true); // [R06] [R10]
  end

endmodule : shift4_reg

// [verification/shift4_monitor.sv]
// Purpose: Port checker. Assumes: one clock. Notes: st is the stored word.
`timescale 1ns/1ps
module shift4_monitor
  import shift4_pkg::*;
(input wire logic clk, rst, step_valid, step_ready, step_mode, first_set, first_hold,
 input wire logic [3:0] parallel_in_bit, stage_output,
 input wire logic advance_enable, polarity_true, stages_busy);
  logic [1:0] cnt_reg;
  logic rst_held_reg = 1'b0;
  wire logic [3:0] st = stage_output ^ {4{!polarity_true}};
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt_reg <= 2'h0;
    else cnt_reg <= cnt_reg + 2'(step_valid && step_ready) - 2'(advance_enable && cnt_reg != 2'h0);
  end
  always_ff @(posedge clk) begin
    rst_held_reg <= rst;
  end
  sequence s_apply(bit m);
    step_valid && step_ready && step_mode == m && !stages_busy && !advance_enable ##1 advance_enable;
  endsequence
  chk_stable_idle: assert property (!$past(advance_enable && stages_busy) |-> $stable(st))
    else $error("Stages moved without a step.");
  chk_reset_out: assert property (disable iff (1'b0) rst && rst_held_reg |->
    stage_output == {4{!polarity_true}} && step_ready && !stages_busy) else $error("Bad reset.");
  chk_reset_clear: assert property ($fell(rst) |-> st == 4'h0)
    else $error("Stages not clear after reset.");
  chk_polarity_flip: assert property (!$past(advance_enable && stages_busy) &&
    $changed(polarity_true) |-> stage_output == ~$past(stage_output)) else $error("Bad polarity.");
  chk_ready_full: assert property (step_ready == (cnt_reg != 2'h2)) else $error("Bad ready.");
  chk_busy_count: assert property (stages_busy == (cnt_reg != 2'h0)) else $error("Bad busy.");
  chk_load_apply: assert property (s_apply(1) |=> st == $past(parallel_in_bit, 2))
    else $error("Bad load.");
  chk_shift_apply: assert property (s_apply(0) |=> st[3:1] == $past(st[2:0]) &&
    st[0] == ($past(st[0]) ? $past(first_hold, 2) : $past(first_set, 2))) else $error("Bad shift.");
endmodule : shift4_monitor
bind shift4_reg shift4_monitor mon (.clk, .rst, .step_valid, .step_ready, .step_mode, .first_set,
  .first_hold, .parallel_in_bit, .stage_output, .advance_enable, .polarity_true, .stages_busy);

// [verification/step_source.sv]
// Purpose: Step offerer. Assumes: ready from a register. Notes: data scrambled when idle.
`timescale 1ns/1ps
module step_source
  import shift4_pkg::*;
(input wire logic clk, step_ready, output logic step_valid, output step_t w);
  initial begin
    step_valid = 1'b0;
    w = '0;
  end
  task automatic send(input step_t x);
    @(negedge clk);
    step_valid = 1'b1;
    w = x;
    while (!step_ready) @(negedge clk);
    @(negedge clk);
    step_valid = 1'b0;
    w = ~x;
  endtask : send
endmodule : step_source

// [verification/tb_top.sv]
// Purpose: Bench. Assumes: drive on falling edge. Notes: rows hold step and stored word.
`timescale 1ns/1ps
module tb_top;
  import shift4_pkg::*;
  logic clk = 1'b0, rst = 1'b1, advance_enable = 1'b0, polarity_true = 1'b1;
  logic step_valid, step_ready, stages_busy;
  logic [3:0] stage_output;
  step_t w;
  int failures = 0, tests_run = 0;
  logic [10:0] rows [8] = '{11'h4aa, 11'h205, 11'h20a, 11'h104, 11'h309, 11'h303, 11'h006,
    11'h4ff};
  shift4_reg uut (.clk, .rst, .step_valid, .step_ready, .step_mode(w[STEP_MODE_BIT]),
    .first_set(w[STEP_SET_BIT]), .first_hold(w[STEP_HOLD_BIT]),
    .parallel_in_bit(w[STEP_PAR_LSB +: STAGE_COUNT]), .advance_enable, .polarity_true,
    .stage_output, .stages_busy);
  step_source src (.clk, .step_ready, .step_valid, .w);
  initial forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  task automatic chk(input logic [5:0] e);
    tests_run++;
    if ({step_ready, stages_busy, stage_output} !== e) begin
      failures++;
      $display("Error %0t: outputs %h, expected %h", $time,
        {step_ready, stages_busy, stage_output}, e);
    end
  endtask : chk
  task automatic adv(input int n);
    advance_enable = 1'b1;
    repeat (n) @(negedge clk);
    advance_enable = 1'b0;
  endtask : adv
  task automatic print_verdict;
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(negedge clk);
    chk(6'h20);
    rst = 1'b0;
    foreach (rows[i]) begin
      src.send(rows[i][10:4]);
      adv(1);
      chk({2'b10, rows[i][3:0]});
    end
    polarity_true = 1'b0;
    #1 chk(6'h20);
    @(negedge clk) polarity_true = 1'b1;
    src.send(7'h41);
    src.send(7'h42);
    chk(6'h1f);
    adv(3);
    chk(6'h22);
    polarity_true = 1'b0;
    rst = 1'b1;
    #1 chk(6'h2f);
    src.send(7'h4f);
    adv(1);
    rst = 1'b0;
    @(negedge clk) chk(6'h2f);
    src.send(7'h45);
    adv(1);
    chk(6'h2a);
    print_verdict();
  end
  initial begin
    #20000;
    failures++;
    print_verdict();
  end
endmodule : tb_top
